// ---- design/msq_sequencer.sv ----
// scrub, code-field init and dump sequencer for an ecc protected sram array
// Notes on behaviour
// - scrub reads each entry through check path first
// - single-bit error: corrected read, then write-back
// - error-free entries are never written back by scrub
// - uncorrectable error halts and flags test failure
// - first check sets skip flag without single-bit error
// - corrected read stalls until skip flag updated
// - recheck bit 4 after write-back, fail if set
// - init reads corrected, writes through code generation
// - init recheck fails on correctable or uncorrectable
// - init keeps already valid entries unchanged
// - trigger and suspend enable: each capture read advances dump
// - everything sampled and driven on rising aclk
// - system reset is active low
// - override high forces internal clock gates open
// - test-failed output only while signal enable set
`timescale 1ns/1ns
`include "msq_defs.svh"
module msq_sequencer (
  // clock, reset, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic                   test_clock_gate_override,
  // axi4-lite write
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  // axi4-lite read
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // memory transaction port
  output logic                        mem_read_en,
  output logic                        mem_write_en,
  output msq_pkg::msq_path_t          mem_path,
  output logic [15:0]                 mem_addr,
  output logic [31:0]                 mem_wdata,
  input  wire logic [31:0]            mem_rdata,
  // core mode control and status
  output logic                        mbist_module_reset,
  output logic                        mbist_mode_request,
  output logic                        test_active,
  output logic                        test_ended,
  output logic                        test_failed
);
  import msq_pkg::*;

  msq_core_t c_r;
  msq_core_t c_nxt;
  msq_reg_if rif ();

  logic        start;
  logic        seq_gate;
  logic        cap_read;
  logic        last_addr;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;
  logic [31:0] wmask;

  msq_axil_slave u_axs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register views and decode

  always_comb
  begin
    ctrl_val = '0;
    ctrl_val[`MSQ_CTRL_EXEC] = c_r.exec_en;
    ctrl_val[`MSQ_CTRL_SUSP] = c_r.susp_req;
    ctrl_val[`MSQ_CTRL_TRIG] = c_r.trig_en;
    ctrl_val[`MSQ_CTRL_FSIG] = c_r.fail_sig_en;
    ctrl_val[`MSQ_CTRL_ESIG] = c_r.end_sig_en;
    ctrl_val[`MSQ_CTRL_MRST] = c_r.mod_reset;
    ctrl_val[`MSQ_CTRL_MBIST_MODE_REQUEST] = c_r.mode_req;
    ctrl_val[`MSQ_CTRL_PROG_HI:`MSQ_CTRL_PROG_LO] = c_r.prog;
    ctrl_val[`MSQ_CTRL_SKIP] = c_r.skip_flag;
    stat_val = '0;
    stat_val[`MSQ_STAT_ACTIVE] = c_r.state != MSQ_ST_IDLE;
    stat_val[`MSQ_STAT_SUSP]   = c_r.state == MSQ_ST_SUSP;
    stat_val[`MSQ_STAT_ENDED]  = c_r.ended;
    stat_val[`MSQ_STAT_FAILED] = c_r.failed;
    stat_val[`MSQ_STAT_UNCORR] = c_r.uncorr;
  end

  always_comb
  begin
    rif.rd_err  = 1'b0;
    rif.rd_data = '0;
    unique case (rif.rd_addr)
      `MSQ_CTRL_OFS:     rif.rd_data = ctrl_val;
      `MSQ_STAT_OFS:     rif.rd_data = stat_val;
      `MSQ_ROWSTART_OFS: rif.rd_data = {16'h0000, c_r.row_start};
      `MSQ_ENDADDR_OFS:  rif.rd_data = {16'h0000, c_r.end_addr};
      `MSQ_CURADDR_OFS:  rif.rd_data = {16'h0000, c_r.cur_addr};
      `MSQ_CAPTURE_OFS:  rif.rd_data = c_r.capture;
      `MSQ_FAILADDR_OFS: rif.rd_data = {16'h0000, c_r.fail_addr};
      default:           rif.rd_err  = 1'b1;
    endcase
  end

  // cur_addr, capture and fail_addr are read-only: writes answer slverr
  always_comb
  begin
    unique case (rif.wr_addr)
      `MSQ_CTRL_OFS, `MSQ_STAT_OFS, `MSQ_ROWSTART_OFS, `MSQ_ENDADDR_OFS:
        rif.wr_err = 1'b0;
      default:
        rif.wr_err = 1'b1;
    endcase
  end

  // byte lanes expanded from the write strobes
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[8*i +: 8] = {8{rif.wr_strb[i]}};
  end

  assign cap_read  = rif.rd_stb && rif.rd_addr == `MSQ_CAPTURE_OFS;
  assign last_addr = c_r.cur_addr == c_r.end_addr;
  assign start     = rif.wr_stb && rif.wr_addr == `MSQ_CTRL_OFS && rif.wr_strb[0]
                     && rif.wr_data[`MSQ_CTRL_EXEC] && c_r.state == MSQ_ST_IDLE;
  // architectural gate: the sequencer only clocks while busy unless forced
  assign seq_gate  = c_r.state != MSQ_ST_IDLE || start || c_r.ovr_s2;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    c_nxt = c_r;
    c_nxt.ovr_s1 = test_clock_gate_override;
    c_nxt.ovr_s2 = c_r.ovr_s1;

    // software writes first so that hardware sets below win
    if (rif.wr_stb)
    begin
      unique case (rif.wr_addr)
        `MSQ_CTRL_OFS:
        begin
          if (rif.wr_strb[0])
          begin
            c_nxt.exec_en     = rif.wr_data[`MSQ_CTRL_EXEC];
            c_nxt.susp_req    = rif.wr_data[`MSQ_CTRL_SUSP];
            c_nxt.trig_en     = rif.wr_data[`MSQ_CTRL_TRIG];
            c_nxt.fail_sig_en = rif.wr_data[`MSQ_CTRL_FSIG];
            c_nxt.end_sig_en  = rif.wr_data[`MSQ_CTRL_ESIG];
            c_nxt.mod_reset   = rif.wr_data[`MSQ_CTRL_MRST];
            c_nxt.mode_req    = rif.wr_data[`MSQ_CTRL_MBIST_MODE_REQUEST];
          end
          if (rif.wr_strb[1] && c_r.state == MSQ_ST_IDLE)
            c_nxt.prog = msq_prog_t'(rif.wr_data[`MSQ_CTRL_PROG_HI:`MSQ_CTRL_PROG_LO]);
        end
        `MSQ_STAT_OFS:
        begin
          if (rif.wr_strb[0] && rif.wr_data[`MSQ_STAT_ENDED])
            c_nxt.ended = 1'b0;
          if (rif.wr_strb[0] && rif.wr_data[`MSQ_STAT_FAILED])
          begin
            c_nxt.failed = 1'b0;
            c_nxt.uncorr = 1'b0;
          end
        end
        `MSQ_ROWSTART_OFS:
          c_nxt.row_start = (c_r.row_start & ~wmask[15:0]) | (rif.wr_data[15:0] & wmask[15:0]);
        `MSQ_ENDADDR_OFS:
          c_nxt.end_addr = (c_r.end_addr & ~wmask[15:0]) | (rif.wr_data[15:0] & wmask[15:0]);
        default:
          c_nxt.exec_en = c_r.exec_en;
      endcase
    end

    if (seq_gate)
    begin
      // enables are single-cycle pulses unless an abort lands in the issuing cycle, which holds one high while idle
      c_nxt.mem_rd_en = 1'b0;
      c_nxt.mem_wr_en = 1'b0;
      unique case (c_r.state)
        MSQ_ST_IDLE:
        begin
          if (start)
          begin
            c_nxt.cur_addr   = c_r.row_start;
            c_nxt.skip_flag  = 1'b0;
            c_nxt.skip_valid = 1'b0;
            c_nxt.ended      = 1'b0;
            c_nxt.phase      = `MSQ_PH_ISSUE;
            // program select written with the start bit counts already
            unique case (c_nxt.prog)
              MSQ_PROG_SCRUB: c_nxt.state = MSQ_ST_CHECK;
              MSQ_PROG_INIT:  c_nxt.state = MSQ_ST_CORR;
              default:        c_nxt.state = MSQ_ST_DUMP;
            endcase
          end
        end
        MSQ_ST_CHECK:
        begin
          unique case (c_r.phase)
            `MSQ_PH_ISSUE:
            begin
              c_nxt.mem_rd_en = 1'b1;
              c_nxt.mem_path  = MSQ_PATH_CHECK;
              c_nxt.mem_addr  = c_r.cur_addr;
              c_nxt.phase     = `MSQ_PH_GAP;
            end
            `MSQ_PH_GAP:
              c_nxt.phase = `MSQ_PH_DATA;
            default:
            begin
              c_nxt.phase = `MSQ_PH_ISSUE;
              if (mem_rdata[`MSQ_ERR_UE_BIT])
              begin
                c_nxt.failed    = 1'b1;
                c_nxt.uncorr    = 1'b1;
                c_nxt.fail_addr = c_r.cur_addr;
                c_nxt.state     = MSQ_ST_IDLE;
              end
              else
              begin
                c_nxt.skip_flag  = !mem_rdata[`MSQ_ERR_CE_BIT];
                c_nxt.skip_valid = 1'b1;
                c_nxt.state      = MSQ_ST_CORR;
              end
            end
          endcase
        end
        MSQ_ST_CORR:
        begin
          unique case (c_r.phase)
            `MSQ_PH_ISSUE:
            begin
              // scrub waits for the check result before it may read
              if (c_r.prog == MSQ_PROG_SCRUB && !c_r.skip_valid)
                c_nxt.phase = `MSQ_PH_ISSUE;
              else if (c_r.prog == MSQ_PROG_SCRUB && c_r.skip_flag)
                c_nxt.state = MSQ_ST_NEXT;
              else
              begin
                c_nxt.mem_rd_en = 1'b1;
                c_nxt.mem_path  = MSQ_PATH_CORRECT;
                c_nxt.mem_addr  = c_r.cur_addr;
                c_nxt.phase     = `MSQ_PH_GAP;
              end
            end
            `MSQ_PH_GAP:
              c_nxt.phase = `MSQ_PH_DATA;
            default:
            begin
              c_nxt.corr_data = mem_rdata;
              c_nxt.phase     = `MSQ_PH_ISSUE;
              c_nxt.state     = MSQ_ST_WBACK;
            end
          endcase
        end
        MSQ_ST_WBACK:
        begin
          if (c_r.phase == `MSQ_PH_ISSUE)
          begin
            // corrected value back through code generation keeps valid data intact
            c_nxt.mem_wr_en = 1'b1;
            c_nxt.mem_path  = MSQ_PATH_CODEGEN;
            c_nxt.mem_addr  = c_r.cur_addr;
            c_nxt.mem_wdata = c_r.corr_data;
            c_nxt.phase     = `MSQ_PH_GAP;
          end
          else
          begin
            c_nxt.phase = `MSQ_PH_ISSUE;
            c_nxt.state = MSQ_ST_RECHK;
          end
        end
        MSQ_ST_RECHK:
        begin
          unique case (c_r.phase)
            `MSQ_PH_ISSUE:
            begin
              c_nxt.mem_rd_en = 1'b1;
              c_nxt.mem_path  = MSQ_PATH_CHECK;
              c_nxt.mem_addr  = c_r.cur_addr;
              c_nxt.phase     = `MSQ_PH_GAP;
            end
            `MSQ_PH_GAP:
              c_nxt.phase = `MSQ_PH_DATA;
            default:
            begin
              c_nxt.phase = `MSQ_PH_ISSUE;
              c_nxt.state = MSQ_ST_NEXT;
              if (mem_rdata[`MSQ_ERR_CE_BIT]
                  || (c_r.prog == MSQ_PROG_INIT && mem_rdata[`MSQ_ERR_UE_BIT]))
              begin
                c_nxt.failed    = 1'b1;
                c_nxt.uncorr    = mem_rdata[`MSQ_ERR_UE_BIT];
                c_nxt.fail_addr = c_r.cur_addr;
                c_nxt.state     = MSQ_ST_IDLE;
              end
            end
          endcase
        end
        MSQ_ST_DUMP:
        begin
          unique case (c_r.phase)
            `MSQ_PH_ISSUE:
            begin
              c_nxt.mem_rd_en = 1'b1;
              c_nxt.mem_path  = MSQ_PATH_DIRECT;
              c_nxt.mem_addr  = c_r.cur_addr;
              c_nxt.phase     = `MSQ_PH_GAP;
            end
            `MSQ_PH_GAP:
              c_nxt.phase = `MSQ_PH_DATA;
            default:
            begin
              c_nxt.capture = mem_rdata;
              c_nxt.phase   = `MSQ_PH_ISSUE;
              // with trigger and suspend set, the prefetched entry waits for the next capture read
              c_nxt.state   = (c_r.trig_en && c_r.susp_req) ? MSQ_ST_SUSP : MSQ_ST_NEXT;
            end
          endcase
        end
        MSQ_ST_SUSP:
        begin
          if (cap_read || !c_r.susp_req)
            c_nxt.state = MSQ_ST_NEXT;
        end
        default:
        begin
          c_nxt.skip_valid = 1'b0;
          c_nxt.phase      = `MSQ_PH_ISSUE;
          if (last_addr)
          begin
            c_nxt.ended = 1'b1;
            c_nxt.state = MSQ_ST_IDLE;
          end
          else
          begin
            c_nxt.cur_addr = c_r.cur_addr + 16'h0001;
            unique case (c_r.prog)
              MSQ_PROG_SCRUB: c_nxt.state = MSQ_ST_CHECK;
              MSQ_PROG_INIT:  c_nxt.state = MSQ_ST_CORR;
              default:        c_nxt.state = MSQ_ST_DUMP;
            endcase
          end
        end
      endcase
      // clearing the enable aborts a running program
      if (!c_nxt.exec_en && c_r.state != MSQ_ST_IDLE)
        c_nxt.state = MSQ_ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register: synchronous active-low reset, ce freezes everything

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c_r           <= '0;
      c_r.prog      <= MSQ_PROG_SCRUB;
      c_r.state     <= MSQ_ST_IDLE;
      c_r.mem_path  <= MSQ_PATH_DIRECT;
      c_r.row_start <= `MSQ_ADDR_RST;
      c_r.end_addr  <= `MSQ_ADDR_RST;
      c_r.capture   <= `MSQ_DATA_RST;
    end
    else if (ce)
      c_r <= c_nxt;
  end

  assign mem_read_en        = c_r.mem_rd_en;
  assign mem_write_en       = c_r.mem_wr_en;
  assign mem_path           = c_r.mem_path;
  assign mem_addr           = c_r.mem_addr;
  assign mem_wdata          = c_r.mem_wdata;
  assign mbist_module_reset = c_r.mod_reset;
  assign mbist_mode_request = c_r.mode_req;
  assign test_active        = c_r.state != MSQ_ST_IDLE;
  assign test_ended         = c_r.ended && c_r.end_sig_en;
  assign test_failed        = c_r.failed && c_r.fail_sig_en;

endmodule : msq_sequencer

// ---- design/msq_defs.svh ----
// register map, field positions, reset values and widths of the maintenance sequencer
`ifndef MSQ_DEFS_SVH
`define MSQ_DEFS_SVH

`define MSQ_AXI_AW        8
`define MSQ_MEM_AW        16
`define MSQ_MEM_DW        32

`define MSQ_CTRL_OFS      8'h00
`define MSQ_STAT_OFS      8'h04
`define MSQ_ROWSTART_OFS  8'h08
`define MSQ_ENDADDR_OFS   8'h0c
`define MSQ_CURADDR_OFS   8'h10
`define MSQ_CAPTURE_OFS   8'h14
`define MSQ_FAILADDR_OFS  8'h18

`define MSQ_CTRL_EXEC     0
`define MSQ_CTRL_SUSP     1
`define MSQ_CTRL_TRIG     2
`define MSQ_CTRL_FSIG     3
`define MSQ_CTRL_ESIG     4
`define MSQ_CTRL_MRST     5
`define MSQ_CTRL_MBIST_MODE_REQUEST     6
`define MSQ_CTRL_PROG_LO  8
`define MSQ_CTRL_PROG_HI  9
`define MSQ_CTRL_SKIP     12

`define MSQ_STAT_ACTIVE   0
`define MSQ_STAT_SUSP     1
`define MSQ_STAT_ENDED    2
`define MSQ_STAT_FAILED   3
`define MSQ_STAT_UNCORR   4

`define MSQ_ERR_CE_BIT    4
`define MSQ_ERR_UE_BIT    5

`define MSQ_ADDR_RST      16'h0000
`define MSQ_DATA_RST      32'h0000_0000

`define MSQ_PH_ISSUE      2'h0
`define MSQ_PH_GAP        2'h1
`define MSQ_PH_DATA       2'h2

`define MSQ_RESP_OKAY     2'h0
`define MSQ_RESP_SLVERR   2'h2

`endif

// ---- design/msq_pkg.sv ----
// types shared by the maintenance sequencer modules
package msq_pkg;

  typedef enum logic [1:0] {
    MSQ_PROG_SCRUB = 2'h0,
    MSQ_PROG_INIT  = 2'h1,
    MSQ_PROG_DUMP  = 2'h2,
    MSQ_PROG_RSVD  = 2'h3
  } msq_prog_t;

  // memory access path selector
  typedef enum logic [1:0] {
    MSQ_PATH_DIRECT  = 2'h0,
    MSQ_PATH_CODEGEN = 2'h1,
    MSQ_PATH_CHECK   = 2'h2,
    MSQ_PATH_CORRECT = 2'h3
  } msq_path_t;

  typedef enum logic [7:0] {
    MSQ_ST_IDLE  = 8'h01,
    MSQ_ST_CHECK = 8'h02,
    MSQ_ST_CORR  = 8'h04,
    MSQ_ST_WBACK = 8'h08,
    MSQ_ST_RECHK = 8'h10,
    MSQ_ST_DUMP  = 8'h20,
    MSQ_ST_SUSP  = 8'h40,
    MSQ_ST_NEXT  = 8'h80
  } msq_state_t;

  typedef struct packed {
    logic        ovr_s1;
    logic        ovr_s2;
    logic        exec_en;
    logic        susp_req;
    logic        trig_en;
    logic        fail_sig_en;
    logic        end_sig_en;
    logic        mod_reset;
    logic        mode_req;
    msq_prog_t   prog;
    logic        skip_flag;
    logic        skip_valid;
    logic        ended;
    logic        failed;
    logic        uncorr;
    logic [15:0] row_start;
    logic [15:0] end_addr;
    logic [15:0] cur_addr;
    logic [15:0] fail_addr;
    logic [31:0] capture;
    logic [31:0] corr_data;
    msq_state_t  state;
    logic [1:0]  phase;
    logic        mem_rd_en;
    logic        mem_wr_en;
    msq_path_t   mem_path;
    logic [15:0] mem_addr;
    logic [31:0] mem_wdata;
  } msq_core_t;

  typedef struct packed {
    logic        have_aw;
    logic        have_w;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } msq_axs_t;

endpackage : msq_pkg

// ---- design/msq_reg_if.sv ----
// register access strobes between the bus slave and the sequencer core
`timescale 1ns/1ns
interface msq_reg_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                input  wr_err, rd_data, rd_err);
  modport regs (input  wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : msq_reg_if

// ---- design/msq_axil_slave.sv ----
// axi4-lite slave front end that turns channel handshakes into register strobes
`timescale 1ns/1ns
`include "msq_defs.svh"
module msq_axil_slave (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address and data
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  msq_reg_if.bus           rif
);
  import msq_pkg::*;

  msq_axs_t s_r;
  msq_axs_t s_nxt;

  // one write and one read outstanding; ce low stalls every channel
  assign awready = ce && !s_r.have_aw && !s_r.bvalid;
  assign wready  = ce && !s_r.have_w && !s_r.bvalid;
  assign arready = ce && !s_r.rvalid;

  assign bresp  = s_r.bresp;
  assign bvalid = s_r.bvalid;
  assign rdata  = s_r.rdata;
  assign rresp  = s_r.rresp;
  assign rvalid = s_r.rvalid;

  assign rif.wr_stb  = ce && s_r.have_aw && s_r.have_w && !s_r.bvalid;
  assign rif.wr_addr = s_r.waddr;
  assign rif.wr_data = s_r.wdata;
  assign rif.wr_strb = s_r.wstrb;
  assign rif.rd_stb  = arvalid && arready;
  assign rif.rd_addr = araddr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    if (awvalid && awready)
    begin
      s_nxt.have_aw = 1'b1;
      s_nxt.waddr   = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.have_w = 1'b1;
      s_nxt.wdata  = wdata;
      s_nxt.wstrb  = wstrb;
    end
    if (rif.wr_stb)
    begin
      s_nxt.have_aw = 1'b0;
      s_nxt.have_w  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = rif.wr_err ? `MSQ_RESP_SLVERR : `MSQ_RESP_OKAY;
    end
    if (ce && s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    if (ce && s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;
    if (rif.rd_stb)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rif.rd_data;
      s_nxt.rresp  = rif.rd_err ? `MSQ_RESP_SLVERR : `MSQ_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

endmodule : msq_axil_slave

// ---- sim/msq_mem_model.sv ----
// ecc protected sram model standing at the far side of the sequencer
`timescale 1ns/1ns
module msq_mem_model (
  // memory transaction port
  input  wire logic               aclk,
  input  wire logic               mem_read_en,
  input  wire logic               mem_write_en,
  input  wire msq_pkg::msq_path_t mem_path,
  input  wire logic [15:0]        mem_addr,
  input  wire logic [31:0]        mem_wdata,
  output logic [31:0]             mem_rdata
);
  import msq_pkg::*;
  logic [31:0] mem [16];
  logic [1:0]  err [16];
  logic [31:0] q = 32'h0;
  logic        vld = 1'b0;
  int          wr_cnt = 0;
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 32'h5a00_0000 + i;
      err[i] = 2'h0;
    end
  end
  always @(posedge aclk)
  begin
    vld <= mem_read_en;
    // check path: bit4 correctable, bit5 uncorrectable; else corrected data
    if (mem_read_en)
      q <= (mem_path == MSQ_PATH_CHECK) ? {26'h0, err[mem_addr[3:0]], 4'h0} : mem[mem_addr[3:0]];
    // code generation write repairs the entry
    if (mem_write_en)
    begin
      mem[mem_addr[3:0]] <= mem_wdata;
      err[mem_addr[3:0]] <= 2'h0;
      wr_cnt <= wr_cnt + 1;
    end
  end
  // stale data is inverted so a late sample cannot pass by luck
  assign mem_rdata = vld ? q : ~q;
endmodule : msq_mem_model

// ---- sim/msq_sequencer_asserts.sv ----
// port-level checker for the maintenance sequencer
`timescale 1ns/1ns
module msq_sequencer_asserts (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // bus answers
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [1:0]         bresp,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [31:0]        rdata,
  // memory and status
  input wire logic               mem_read_en,
  input wire logic               mem_write_en,
  input wire msq_pkg::msq_path_t mem_path,
  input wire logic               test_active,
  input wire logic               test_failed
);
  import msq_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rechk;
    ##[1:3] (mem_read_en && mem_path == MSQ_PATH_CHECK);
  endsequence
  a_rw_excl: assert property (!(mem_read_en && mem_write_en))
    else $error("read and write together");
  a_rd_pulse: assert property (mem_read_en |=> !mem_read_en [*2])
    else $error("read pulse too close");
  a_wb_source: assert property (mem_write_en |-> mem_path == MSQ_PATH_CODEGEN && $past(mem_path) == MSQ_PATH_CORRECT)
    else $error("write-back not after corrected read");
  a_wb_recheck: assert property (mem_write_en |-> s_rechk)
    else $error("no recheck after write-back");
  a_fail_halt: assert property ($rose(test_failed) |-> ##[0:3] !test_active)
    else $error("failure did not halt");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !mem_read_en && !mem_write_en && !test_active)
    else $error("activity in reset");
endmodule : msq_sequencer_asserts
bind msq_sequencer msq_sequencer_asserts i_msq_sequencer_asserts (.aclk, .aresetn, .bvalid,
  .bready, .bresp, .rvalid, .rready, .rdata, .mem_read_en, .mem_write_en, .mem_path,
  .test_active, .test_failed);

// ---- sim/msq_sequencer_tb.sv ----
// self-checking bench for the maintenance sequencer
`timescale 1ns/1ns
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, v); end end
module msq_sequencer_tb;
  import msq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, mem_wdata, mem_rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, br, r;
  logic [15:0] mem_addr;
  msq_path_t mem_path;
  logic mem_read_en, mem_write_en, mbist_module_reset, mbist_mode_request;
  logic test_active, test_ended, test_failed, ovr = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  always #25 aclk = ~aclk;
  msq_sequencer i_msq_sequencer (.aclk, .aresetn, .ce(1'b1), .test_clock_gate_override(ovr),
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mem_read_en, .mem_write_en,
    .mem_path, .mem_addr, .mem_wdata, .mem_rdata, .mbist_module_reset, .mbist_mode_request,
    .test_active, .test_ended, .test_failed);
  msq_mem_model i_msq_mem_model (.aclk, .mem_read_en, .mem_write_en, .mem_path, .mem_addr,
    .mem_wdata, .mem_rdata);
  task end_sim;
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // handshakes read at the edge, before the design's registers move
  task wr(input logic [7:0] a, input logic [31:0] v);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    {bready, br} <= {1'b0, bresp};
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    {rready, d, r} <= {1'b0, rdata, rresp};
    @(posedge aclk);
  endtask : rd
  // start a program and wait for its end or failure; a hang is left to the watchdog
  task run(input logic [15:0] s, input logic [15:0] e, input logic [31:0] c);
    wr(8'h08, {16'h0, s});
    wr(8'h0c, {16'h0, e});
    wr(8'h00, c);
    while (test_ended !== 1'b1 && test_failed !== 1'b1) @(posedge aclk);
  endtask : run
  task stop;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1c);
  endtask : stop
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h04);
    `CHK("status", 32'h0, d)
    rd(8'h1c);
    `CHK("unmapped", 2'h2, r)
    wr(8'h10, 32'h1);
    `CHK("ro write", 2'h2, br)
    i_msq_mem_model.err[2] = 2'h1;
    run(16'h0, 16'h7, 32'h19);
    `CHK("scrub writes", 1, i_msq_mem_model.wr_cnt)
    `CHK("repaired", 2'h0, i_msq_mem_model.err[2])
    `CHK("scrub end", 3'b001, {test_active, test_failed, test_ended})
    stop();
    i_msq_mem_model.err[5] = 2'h2;
    run(16'h0, 16'h7, 32'h19);
    `CHK("uncorr fail", 1'b1, test_failed)
    rd(8'h18);
    `CHK("fail addr", 32'h5, d)
    wr(8'h00, 32'h0);
    `CHK("fail gated", 1'b0, test_failed)
    rd(8'h04);
    `CHK("fail kept", 32'h18, d)
    wr(8'h04, 32'h1c);
    i_msq_mem_model.err[5] = 2'h0;
    i_msq_mem_model.err[1] = 2'h1;
    ovr <= 1'b1;
    run(16'h0, 16'h3, 32'h119);
    `CHK("init writes", 5, i_msq_mem_model.wr_cnt)
    `CHK("init pass", 1'b0, test_failed)
    for (int i = 0; i < 4; i++) `CHK("init data", 32'h5a00_0000 + i, i_msq_mem_model.mem[i])
    stop();
    wr(8'h00, 32'h60);
    `CHK("mode", 2'b11, {mbist_module_reset, mbist_mode_request})
    wr(8'h08, 32'h8);
    wr(8'h0c, 32'hb);
    wr(8'h00, 32'h247);
    // a capture read counts only once the entry is fetched and the program suspended
    for (int i = 8; i < 12; i++)
    begin
      do
        rd(8'h04);
      while (d[1] !== 1'b1);
      rd(8'h14);
      `CHK("dump", 32'h5a00_0000 + i, d)
    end
    rd(8'h04);
    `CHK("dump end", 32'h4, d)
    end_sim();
  end
  initial
  begin
    #2_000_000;
    miscompares++;
    end_sim();
  end
endmodule : msq_sequencer_tb
